// >>> src/ssap_pkg.sv
// Package of constants for the SPI slave attention port
`default_nettype none
package ssap_pkg;
   localparam int unsigned SYS_CLK_MHZ = 250;
   localparam real MAX_LINK_MBPS = 3.5;
   // Shortest link clock half period, rounded down to whole system cycles
   localparam int unsigned MIN_HALF_CYC = int'($floor(real'(SYS_CLK_MHZ) / (2.0 * MAX_LINK_MBPS)));
   localparam int unsigned BYTE_W = 8;
   localparam logic [2:0] BIT_MSB = 3'h7;
   localparam logic [2:0] BIT_ZERO = 3'h0;
   localparam logic [7:0] FILL_BYTE = 8'hff;
   localparam logic [7:0] API_DELIM = 8'h7e;
   localparam logic CFG_PERIPH = 1'b1;
   // Pin-sleep source selection
   typedef enum logic [2:0] {
      SSAP_WAKE_FORCED = 3'b001,
      SSAP_WAKE_SLEEPPIN = 3'b010,
      SSAP_WAKE_SELECT = 3'b100
   } ssap_wake_src_t;
endpackage : ssap_pkg
`default_nettype wire

// >>> src/ssap_sync.sv
// Three-flop input synchroniser with agreement-based change detection
`default_nettype none
module ssap_sync (
   input wire logic clk_sys, // System clock
   input wire logic reset, // Synchronous reset
   input wire logic en, // Clock enable
   input wire logic rst_val, // Value held during reset
   input wire logic async_in, // Pin from outside the domain
   output logic sync_out // Filtered level
);
   logic s1_q, s2_q, s3_q, out_q;
   logic s1_d, s2_d, s3_d, out_d;

   // Next values: first stage read only by the second
   always_comb begin
      s1_d = async_in;
      s2_d = s1_q;
      s3_d = s2_q;
      out_d = (s2_q == s3_q) ? s3_q : out_q; // RULE20
   end

   // Register stages
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s1_q <= rst_val;
         s2_q <= rst_val;
         s3_q <= rst_val;
         out_q <= rst_val;
      end else if (en) begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         out_q <= out_d;
      end
   end

   assign sync_out = out_q;
endmodule : ssap_sync
`default_nettype wire

// >>> src/ssap_core.sv
// SPI mode 0 slave port with attention output and pin-sleep control
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RULE1: Slave only; master owns clock and timing
// RULE2: Works with link clock up to 3.5 Mbps
// RULE3: Mode 0, sample rising edge, MSB first
// RULE4: Attention low while data queued, always driven
// RULE5: Master selects and clocks when attention asserts
// RULE6: Shift MISO one bit per clock while selected
// RULE7: MISO released whenever select is high
// RULE8: Master selects low, deselects high
// RULE9: Master presents MOSI data at clock rate
// RULE10: MOSI, select, clock are inputs only
// RULE11: Pull-ups on by default, software may disable
// RULE12: Traffic is unescaped API frames only
// RULE13: Full duplex bytes; discard bytes outside frames (code delivers every byte, with rx_in_frame low outside frames)
// RULE14: Keep up with simultaneous traffic both ways
// RULE15: Sleep-request pin controls pin sleep by default
// RULE16: Else select pin controls sleep, low wakes
// RULE17: Neither configured: stay awake, ignore sleep mode
// RULE18: Attention held until all queued bytes out
// RULE19: Empty buffer repeats last valid MISO bit
// RULE20: Synchronise link inputs before edge detection
module ssap_core (
   input wire logic clk_sys, // 250 MHz system clock
   input wire logic reset, // Synchronous reset, active high
   input wire logic clk_en, // Freezes all state while low
   input wire logic sclk_pin, // Link clock from master
   input wire logic ssel_n_pin, // Slave select, active low
   input wire logic mosi_pin, // Master data in
   output logic miso_o, // MISO output level
   output logic miso_oe, // MISO drive enable
   output logic attention_out_n, // Data queued, active low
   output logic attention_oe, // Attention drive enable
   input wire logic [7:0] tx_data, // Byte offered for sending
   input wire logic tx_valid, // Byte offered
   output logic tx_ready, // Byte taken this cycle
   input wire logic tx_more, // More bytes queued behind this one
   output logic [7:0] rx_data, // Received byte
   output logic rx_valid, // Received byte pulse
   output logic rx_in_frame, // Byte lies inside an API frame
   input wire logic pullup_config, // Pull-up enable setting
   output logic pullup_en, // Pull-up enable to pads
   input wire logic sleep_pin_io, // Sleep request pin level
   input wire logic sleep_pin_periph, // Sleep pin configured as peripheral
   input wire logic select_pin_config, // Select pin configured as peripheral
   input wire logic pin_sleep_mode, // Pin sleep mode selected
   output logic sleep_req // Request to sleep
);
   logic sclk_s, ssel_n_s, mosi_s;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   ssap_sync u_sync_sclk (.clk_sys(clk_sys), .reset(reset), .en(clk_en), .rst_val(1'b0),
      .async_in(sclk_pin), .sync_out(sclk_s)); // RULE10 RULE20
   ssap_sync u_sync_ssel (.clk_sys(clk_sys), .reset(reset), .en(clk_en), .rst_val(1'b1),
      .async_in(ssel_n_pin), .sync_out(ssel_n_s)); // RULE10 RULE20
   ssap_sync u_sync_mosi (.clk_sys(clk_sys), .reset(reset), .en(clk_en), .rst_val(1'b0),
      .async_in(mosi_pin), .sync_out(mosi_s)); // RULE10 RULE20

   ////////////////////////////////////////////////////////////////////////////
   // Shifter state
   logic sclk_q, sclk_d;
   logic [2:0] bit_q, bit_d;
   logic [7:0] rx_sh_q, rx_sh_d, tx_sh_q, tx_sh_d;
   logic miso_q, miso_d, miso_oe_q, miso_oe_d;
   logic [7:0] rx_data_q, rx_data_d;
   logic rx_valid_q, rx_valid_d, in_frame_q, in_frame_d, rx_in_frame_q, rx_in_frame_d;
   logic have_q, have_d, tx_ready_q, tx_ready_d, more_q, more_d, attn_n_q, attn_n_d;
   logic rise, fall, selected;

   // Edge detection on the filtered link clock
   always_comb begin
      selected = ~ssel_n_s; // RULE8
      rise = sclk_s & ~sclk_q; // RULE3 RULE1
      fall = ~sclk_s & sclk_q; // RULE2
   end

   // Next-state logic of the shifter and queue flag
   always_comb begin
      sclk_d = sclk_s;
      bit_d = bit_q;
      rx_sh_d = rx_sh_q;
      tx_sh_d = tx_sh_q;
      miso_d = miso_q;
      rx_data_d = rx_data_q;
      rx_valid_d = 1'b0;
      in_frame_d = in_frame_q;
      rx_in_frame_d = rx_in_frame_q;
      have_d = have_q;
      more_d = more_q;
      tx_ready_d = 1'b0;
      miso_oe_d = selected; // RULE7
      // Load only on a byte boundary so no byte goes out cut short
      if (!have_q && tx_valid && !tx_ready_q &&
         (!selected || (bit_q == ssap_pkg::BIT_MSB && !rise))) begin
         tx_sh_d = tx_data;
         have_d = 1'b1;
         more_d = tx_more;
         tx_ready_d = 1'b1;
      end
      if (!selected) begin
         bit_d = ssap_pkg::BIT_MSB;
      end else if (rise) begin
         rx_sh_d = {rx_sh_q[6:0], mosi_s}; // RULE3
         if (bit_q == ssap_pkg::BIT_ZERO) begin
            bit_d = ssap_pkg::BIT_MSB;
            rx_data_d = {rx_sh_q[6:0], mosi_s}; // RULE13
            rx_valid_d = 1'b1; // RULE14
            if ({rx_sh_q[6:0], mosi_s} == ssap_pkg::API_DELIM) begin
               in_frame_d = 1'b1; // RULE12
            end
            rx_in_frame_d = in_frame_d | in_frame_q; // RULE13
            if (have_q) begin
               have_d = 1'b0; // RULE18
            end
         end else begin
            bit_d = bit_q - 3'h1;
         end
      end else if (fall && have_q) begin
         miso_d = tx_sh_q[bit_q]; // RULE6
      end
      // Frame tracking resets when the master deselects
      if (!selected) begin
         in_frame_d = 1'b0;
      end
      // Present the first bit ahead of the first rising edge
      if (selected && have_d && bit_d == ssap_pkg::BIT_MSB && !rise) begin
         miso_d = tx_sh_d[ssap_pkg::BIT_MSB]; // RULE19
      end
      attn_n_d = ~(have_d | more_d | tx_valid); // RULE4
   end

   // Register shifter state
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sclk_q <= 1'b0;
         bit_q <= ssap_pkg::BIT_MSB;
         rx_sh_q <= 8'h00;
         tx_sh_q <= ssap_pkg::FILL_BYTE;
         miso_q <= 1'b1;
         miso_oe_q <= 1'b0;
         rx_data_q <= 8'h00;
         rx_valid_q <= 1'b0;
         in_frame_q <= 1'b0;
         rx_in_frame_q <= 1'b0;
         have_q <= 1'b0;
         more_q <= 1'b0;
         tx_ready_q <= 1'b0;
         attn_n_q <= 1'b1;
      end else if (clk_en) begin
         sclk_q <= sclk_d;
         bit_q <= bit_d;
         rx_sh_q <= rx_sh_d;
         tx_sh_q <= tx_sh_d;
         miso_q <= miso_d;
         miso_oe_q <= miso_oe_d;
         rx_data_q <= rx_data_d;
         rx_valid_q <= rx_valid_d;
         in_frame_q <= in_frame_d;
         rx_in_frame_q <= rx_in_frame_d;
         have_q <= have_d;
         more_q <= more_d;
         tx_ready_q <= tx_ready_d;
         attn_n_q <= attn_n_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin sleep and pull-up control
   ssap_pkg::ssap_wake_src_t src;
   logic sleep_q, sleep_d, pull_q, pull_d, oe_q, oe_d;

   // Pick the sleep source and its level
   always_comb begin
      if (sleep_pin_periph == ssap_pkg::CFG_PERIPH) begin
         src = ssap_pkg::SSAP_WAKE_SLEEPPIN; // RULE15
      end else if (select_pin_config == ssap_pkg::CFG_PERIPH) begin
         src = ssap_pkg::SSAP_WAKE_SELECT; // RULE16
      end else begin
         src = ssap_pkg::SSAP_WAKE_FORCED; // RULE17
      end
      sleep_d = 1'b0;
      unique case (src)
         ssap_pkg::SSAP_WAKE_SLEEPPIN: sleep_d = pin_sleep_mode & sleep_pin_io;
         ssap_pkg::SSAP_WAKE_SELECT: sleep_d = pin_sleep_mode & ssel_n_s; // RULE16
         ssap_pkg::SSAP_WAKE_FORCED: sleep_d = 1'b0; // RULE17
      endcase
      pull_d = pullup_config; // RULE11
      oe_d = 1'b1; // RULE4
   end

   // Register sleep and pull-up outputs
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sleep_q <= 1'b0;
         pull_q <= 1'b1; // RULE11
         oe_q <= 1'b1; // RULE4
      end else if (clk_en) begin
         sleep_q <= sleep_d;
         pull_q <= pull_d;
         oe_q <= oe_d;
      end
   end

   assign miso_o = miso_q;
   assign miso_oe = miso_oe_q;
   assign attention_out_n = attn_n_q;
   assign attention_oe = oe_q; // RULE4
   assign tx_ready = tx_ready_q;
   assign rx_data = rx_data_q;
   assign rx_valid = rx_valid_q;
   assign rx_in_frame = rx_in_frame_q;
   assign pullup_en = pull_q;
   assign sleep_req = sleep_q;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_miso_release;
      @(posedge clk_sys) disable iff (reset || !clk_en) ssel_n_s |=> !miso_oe_q;
   endproperty
   a_miso_release: assert property (p_miso_release) else $error("MISO driven while deselected"); // RULE7
   property p_miso_drive;
      @(posedge clk_sys) disable iff (reset || !clk_en) !ssel_n_s |=> miso_oe_q;
   endproperty
   a_miso_drive: assert property (p_miso_drive) else $error("MISO not driven when selected"); // RULE6
   property p_attn_queued;
      @(posedge clk_sys) disable iff (reset || !clk_en) have_q |-> !attn_n_q;
   endproperty
   a_attn_queued: assert property (p_attn_queued) else $error("Attention high with data"); // RULE18
   property p_attn_idle;
      @(posedge clk_sys) disable iff (reset || !clk_en)
         (!have_q && !more_q && !tx_valid) |=> attn_n_q;
   endproperty
   a_attn_idle: assert property (p_attn_idle) else $error("Attention low with nothing queued"); // RULE4
   property p_rx_byte;
      @(posedge clk_sys) disable iff (reset || !clk_en)
         (rise && selected && bit_q == ssap_pkg::BIT_ZERO) |=> rx_valid_q;
   endproperty
   a_rx_byte: assert property (p_rx_byte) else $error("Byte not delivered"); // RULE13
   property p_rx_pulse;
      @(posedge clk_sys) disable iff (reset || !clk_en) rx_valid_q |=> !rx_valid_q;
   endproperty
   a_rx_pulse: assert property (p_rx_pulse) else $error("Receive pulse too long"); // RULE14
   property p_sleep_forced;
      @(posedge clk_sys) disable iff (reset || !clk_en)
         (!sleep_pin_periph && !select_pin_config) |=> !sleep_q;
   endproperty
   a_sleep_forced: assert property (p_sleep_forced) else $error("Slept with no source"); // RULE17
   property p_sleep_select;
      @(posedge clk_sys) disable iff (reset || !clk_en)
         (!sleep_pin_periph && select_pin_config && pin_sleep_mode) |=> sleep_q == $past(ssel_n_s);
   endproperty
   a_sleep_select: assert property (p_sleep_select) else $error("Sleep not following select"); // RULE16
   property p_sleep_pin;
      @(posedge clk_sys) disable iff (reset || !clk_en)
         (sleep_pin_periph && pin_sleep_mode) |=> sleep_q == $past(sleep_pin_io);
   endproperty
   a_sleep_pin: assert property (p_sleep_pin) else $error("Sleep not following pin"); // RULE15
   property p_pullup;
      @(posedge clk_sys) disable iff (reset || !clk_en) 1'b1 |=> pull_q == $past(pullup_config);
   endproperty
   a_pullup: assert property (p_pullup) else $error("Pull-up not following setting"); // RULE11
   c_byte: cover property (@(posedge clk_sys) rx_valid_q && rx_in_frame_q);
   c_tx_take: cover property (@(posedge clk_sys) tx_ready_q ##[1:400] !attn_n_q ##1 attn_n_q);
   c_select_sleep: cover property (@(posedge clk_sys) src == ssap_pkg::SSAP_WAKE_SELECT && sleep_q);
endmodule : ssap_core
`default_nettype wire

// >>> verification/ssap_master.sv
// SPI mode 0 master model driving the link pins of the port
`default_nettype none
module ssap_master #(
   parameter int HALF_NS = 24 // Half of the 48 ns link clock period
) (
   output logic sclk, // Link clock, low outside frames
   output logic ssel_n, // Slave select, active low
   output logic mosi, // Data to the port
   input wire logic miso // Resolved MISO line level
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle: clock still and low, deselected, MOSI at its pull-up level
   initial begin
      sclk = 1'b0;
      ssel_n = 1'b1;
      mosi = 1'b1;
   end
   // Select or deselect, then let half a bit time pass before any edge
   task automatic sel(input logic on);
      ssel_n = !on;
      if (!on) mosi = 1'b1;
      #(HALF_NS);
   endtask : sel
   // One byte both ways, MSB first, both sides sample on the rising edge
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi = tx[i];
         #(HALF_NS);
         sclk = 1'b1;
         rx[i] = miso;
         #(HALF_NS);
         sclk = 1'b0;
      end
   endtask : xfer
endmodule : ssap_master
`default_nettype wire

// >>> verification/tb_ssap_core.sv
// Self-checking testbench of the SPI slave attention port
`default_nettype none
module tb_ssap_core;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, reset = 1'b1, clk_en = 1'b1;
   logic sclk, ssel_n, mosi, miso_o, miso_oe, attn_n, attn_oe, tx_ready, rx_valid, rx_in_frame;
   logic pullup_en, sleep_req, tx_valid = 1'b0, tx_more = 1'b0, pullup_config = 1'b1;
   logic sleep_pin_io = 1'b0, sleep_pin_periph = 1'b1, select_pin_config = 1'b1;
   logic pin_sleep_mode = 1'b1;
   logic [7:0] tx_data = 8'h00, rx_data;
   logic [7:0] txq[$], rxq[$];
   logic frq[$];
   int miscompares = 0, checks_done = 0;
   wire logic miso_line = miso_oe ? miso_o : !miso_o; // Released line does not hold its value
   always #2 clk_sys = ~clk_sys;
   ssap_core i_ssap_core (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .sclk_pin(sclk),
      .ssel_n_pin(ssel_n), .mosi_pin(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
      .attention_out_n(attn_n), .attention_oe(attn_oe), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_more(tx_more), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_in_frame(rx_in_frame), .pullup_config(pullup_config),
      .pullup_en(pullup_en), .sleep_pin_io(sleep_pin_io), .sleep_pin_periph(sleep_pin_periph),
      .select_pin_config(select_pin_config), .pin_sleep_mode(pin_sleep_mode),
      .sleep_req(sleep_req));
   ssap_master i_ssap_master (.sclk(sclk), .ssel_n(ssel_n), .mosi(mosi), .miso(miso_line));
   ////////////////////////////////////////////////////////////////////////////////
   // Offer queued bytes, hold each until taken; collect received bytes
   always @(posedge clk_sys) begin
      if (tx_ready === 1'b1) void'(txq.pop_front());
      tx_valid <= (txq.size() > 0);
      tx_more <= (txq.size() > 1);
      tx_data <= (txq.size() > 0) ? txq[0] : 8'h00;
      if (rx_valid === 1'b1) begin
         rxq.push_back(rx_data);
         frq.push_back(rx_in_frame);
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk1(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask : chk1
   task automatic test_done;
      $display("checks_done %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done
   // Watchdog well beyond the expected run length
   initial begin
      #300000;
      miscompares++;
      test_done();
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [7:0] ex[$], mb[$];
      logic [7:0] got, m;
      logic [31:0] v;
      int n;
      void'($urandom(32'ha1ac));
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      chk1(attn_n, 1'b1);
      chk1(miso_oe, 1'b0);
      chk1(pullup_en, 1'b1);
      @(posedge clk_sys);
      reset <= 1'b0;
      // Full duplex rounds, frame marker first except in round one
      for (int r = 0; r < 3; r++) begin
         n = 1 + $urandom_range(3);
         @(negedge clk_sys);
         ex = {};
         mb = {};
         rxq = {};
         frq = {};
         for (int k = 0; k < n; k++) ex.push_back(8'($urandom));
         for (int k = 0; k < n; k++) txq.push_back(ex[k]);
         repeat (10) @(posedge clk_sys);
         chk1(attn_n, 1'b0);
         // Link pins move away from the system clock's rising edge
         @(negedge clk_sys);
         i_ssap_master.sel(1'b1);
         chk1(miso_oe, 1'b1);
         for (int k = 0; k <= n; k++) begin
            m = (k == 0) ? ((r == 1) ? 8'h55 : 8'h7e) : ((k == 1 && r == 1) ? 8'h7e : 8'($urandom));
            mb.push_back(m);
            i_ssap_master.xfer(m, got);
            chk(got, (k < n) ? ex[k] : {8{ex[n - 1][0]}});
            chk1(attn_n, k >= n - 1);
         end
         i_ssap_master.sel(1'b0);
         repeat (10) @(posedge clk_sys);
         chk1(miso_oe, 1'b0);
         chk(8'(rxq.size()), 8'(n + 1));
         for (int k = 0; k <= n && k < rxq.size(); k++) begin
            chk(rxq[k], mb[k]);
            chk1(frq[k], !(r == 1 && k == 0));
         end
         $display("duplex round %0d done", r);
      end
      // Clock enable low freezes the registered outputs
      @(posedge clk_sys);
      clk_en <= 1'b0;
      pullup_config <= !pullup_en;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      chk1(pullup_en, !pullup_config);
      @(posedge clk_sys);
      clk_en <= 1'b1;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk1(pullup_en, pullup_config);
      $display("clock enable test done");
      // Sleep source priority and pull-up setting over random configurations
      for (int i = 0; i < 16; i++) begin
         v = $urandom;
         @(posedge clk_sys);
         sleep_pin_periph <= v[2];
         sleep_pin_io <= v[1];
         select_pin_config <= v[0];
         pin_sleep_mode <= v[3];
         pullup_config <= v[4];
         @(negedge clk_sys);
         i_ssap_master.sel(i[0]);
         chk1(sleep_req, v[2] ? (v[1] & v[3]) : (v[0] & v[3] & !i[0]));
         chk1(pullup_en, v[4]);
         chk1(attn_oe, 1'b1);
      end
      i_ssap_master.sel(1'b0);
      $display("sleep table done");
      test_done();
   end
endmodule : tb_ssap_core
`default_nettype wire
